// [shared/spr_defines.vh]
// constants for the two-channel setpoint relay controller
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH
// ----------------------------------------
// apb register map
// ----------------------------------------
`define SPR_A_CTRL 8'h00
`define SPR_A_STAT 8'h04
`define SPR_A_SP0 8'h08
`define SPR_A_SP1 8'h0c
`define SPR_CTRL_RST 2'h0
// status fields
`define SPR_ST_RELAY 1:0
`define SPR_ST_FAULT 2
`define SPR_ST_SHOW 3
`define SPR_ST_LOAD 4
// ----------------------------------------
// setpoint word: {digit1, digit2, exponent}
// ----------------------------------------
`define SPR_D1 15:12
`define SPR_D2 11:8
`define SPR_EX 7:0
`define SPR_SP_MIN 16'h10f4
`define SPR_EX_MIN 8'hf4
`define SPR_EX_MAX 8'h05
`define SPR_EX_SPAN 8'h11
`define SPR_EX_BIAS 5'h10
`define SPR_MANT_TOP 7'h5a
// ----------------------------------------
// timing
// ----------------------------------------
`define SPR_CLK_HZ 50000000
`define SPR_SHOW_MS 2000
`define SPR_HOLD_MS 500
`define SPR_SLOW_MS 250
`define SPR_FAST_MS 50
`define SPR_CHK_MS 1000
`define SPR_MS2CYC(ms) ((ms) * (`SPR_CLK_HZ / 1000))
`endif

// [design/spr_ctrl.v]
// two-channel setpoint relay controller with nv storage and apb access
// Notes on behaviour
// - two channels, each drives one relay
// - setpoint: two digits mantissa, one exponent
// - compare display value directly, no units
// - above-atmosphere setpoint: always active, overflow excepted
// - zero setpoint: inactive, reversed polarity active
// - short press shows setpoint two seconds
// - hold steps slow, faster after decade
// - two seconds after release: redisplay, store
// - gauge off deactivates relays; ovr_on still forces a relay on here
// - degas freezes relay states
// - on below setpoint, off above plus 10%+step
// - hysteresis rounds up on second digit five
// - ignore display bus while setpoint shown
// - polarity off activates below setpoint
// - override right forces on, left off
// - setpoints kept in ram copies
// - load at power-up, checksum kept current
// - periodic checksum recompute and compare
// - invalid stored setpoint becomes zero
// - fault indicator on circuit failure
//
// Chosen here: register access over APB and the register offsets.
`include "spr_defines.vh"
`default_nettype none
module spr_ctrl #(
  parameter [31:0] SHOW_CYC = `SPR_MS2CYC(`SPR_SHOW_MS),
  parameter [31:0] HOLD_CYC = `SPR_MS2CYC(`SPR_HOLD_MS),
  parameter [31:0] SLOW_CYC = `SPR_MS2CYC(`SPR_SLOW_MS),
  parameter [31:0] FAST_CYC = `SPR_MS2CYC(`SPR_FAST_MS),
  parameter [31:0] CHK_CYC = `SPR_MS2CYC(`SPR_CHK_MS)
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // display bus snoop
  input wire disp_valid,
  input wire [15:0] disp_word,
  input wire disp_ovf,
  // gauge state
  input wire gauge_on,
  input wire degas,
  // front panel
  input wire btn_up,
  input wire btn_dn,
  input wire chan_sel,
  input wire [1:0] ovr_on,
  input wire [1:0] ovr_off,
  // display of setpoint
  output reg show_sp,
  output reg [15:0] sp_disp_word,
  // relays and fault lamp
  output reg [1:0] process_relay_channel,
  output reg fault_led,
  // non-volatile memory port
  output reg nv_req,
  output reg nv_we,
  output reg nv_addr,
  output reg [15:0] nv_wdata,
  input wire nv_ack,
  input wire [15:0] nv_rdata
);
// ----------------------------------------
// helpers
// ----------------------------------------
function [6:0] mant;
  input [15:0] w;
  begin
    mant = w[`SPR_D1] * 4'ha + {3'h0, w[`SPR_D2]};
  end
endfunction

function [15:0] mk;
  input [6:0] m;
  input [7:0] e;
  reg [6:0] q;
  reg [6:0] r;
  begin
    q = m / 7'd10;
    r = m - q * 7'd10;
    mk = {q[3:0], r[3:0], e};
  end
endfunction

// ordered key: biased exponent, then mantissa; zero sorts lowest
function [11:0] key;
  input [15:0] w;
  begin
    if (mant(w) == 7'h0) begin
      key = 12'h0;
    end else begin
      key = {w[4:0] + `SPR_EX_BIAS, mant(w)};
    end
  end
endfunction

function valid;
  input [15:0] w;
  reg [7:0] eb;
  begin
    eb = w[`SPR_EX] - `SPR_EX_MIN;
    if (w == 16'h0) begin
      valid = 1'b1;
    end else begin
      valid = (w[`SPR_D1] <= 4'h9) && (w[`SPR_D2] <= 4'h9) &&
        (w[`SPR_D1] != 4'h0) && (eb < `SPR_EX_SPAN) &&
        !(w[`SPR_EX] == `SPR_EX_MAX && mant(w) > `SPR_MANT_TOP);
    end
  end
endfunction

// one step; msb flags a decade crossing
function [16:0] step;
  input [15:0] w;
  input up;
  reg [6:0] m;
  reg [7:0] e;
  begin
    m = mant(w);
    e = w[`SPR_EX];
    if (up) begin
      if (m == 7'h0) begin
        step = {1'b0, `SPR_SP_MIN};
      end else if (e == `SPR_EX_MAX && m >= `SPR_MANT_TOP) begin
        step = {1'b0, w};
      end else if (m == 7'h63) begin
        step = {1'b1, 8'h10, e + 8'h1};
      end else begin
        step = {1'b0, mk(m + 7'h1, e)};
      end
    end else begin
      if (m == 7'h0) begin
        step = {1'b0, w};
      end else if (m == 7'ha && e == `SPR_EX_MIN) begin
        step = 17'h0;
      end else if (m == 7'ha) begin
        step = {1'b1, 8'h99, e - 8'h1};
      end else begin
        step = {1'b0, mk(m - 7'h1, e)};
      end
    end
  end
endfunction

// release threshold: setpoint + 10% (rounded) + one step
function [11:0] off_key;
  input [15:0] w;
  reg [7:0] s;
  begin
    s = {1'b0, mant(w)} + {4'h0, w[`SPR_D1]} +
      {7'h0, (w[`SPR_D2] >= 4'h5)} + 8'h1;
    if (s > 8'h63) begin
      off_key = {w[4:0] + `SPR_EX_BIAS + 5'h1,
        (s == 8'h64) ? 7'ha : 7'hb};
    end else begin
      off_key = {w[4:0] + `SPR_EX_BIAS, s[6:0]};
    end
  end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
localparam [3:0] UI_IDLE = 4'b0001;
localparam [3:0] UI_PRESS = 4'b0010;
localparam [3:0] UI_SCROLL = 4'b0100;
localparam [3:0] UI_SHOW = 4'b1000;
localparam [2:0] NV_LOAD = 3'b001;
localparam [2:0] NV_IDLE = 3'b010;
localparam [2:0] NV_WR = 3'b100;

reg [15:0] sp_ram [0:1];
reg [15:0] csum;
reg [1:0] pol;
reg [3:0] ui_st;
reg [2:0] nv_st;
reg [31:0] ui_tmr;
reg [31:0] chk_tmr;
reg ui_ch;
reg ui_up;
reg fast;
reg dirty;
reg [1:0] wr_pend;
reg ld_idx;
reg wr_idx;
reg [11:0] p_key;
reg p_ovf;
reg [1:0] low;

wire btn = btn_up | btn_dn;
wire [15:0] sum = sp_ram[0] + sp_ram[1];
wire loading = nv_st == NV_LOAD;
wire chk_tick = chk_tmr == CHK_CYC - 32'h1;
wire mismatch = chk_tick && !loading && csum != sum;
wire [16:0] stp = step(sp_ram[ui_ch], ui_up);
wire [31:0] rate = fast ? FAST_CYC : SLOW_CYC;
wire do_step = (ui_st == UI_PRESS && ui_tmr == HOLD_CYC - 32'h1) ||
  (ui_st == UI_SCROLL && ui_tmr == rate - 32'h1);
wire [15:0] ld_word = valid(nv_rdata) ? nv_rdata : 16'h0;
wire ld_wr = loading && nv_ack;
wire apb_wr = psel && penable && pwrite;
wire commit = ui_st == UI_SHOW && ui_tmr == SHOW_CYC - 32'h1;

// ----------------------------------------
// apb slave
// ----------------------------------------
assign pready = 1'b1;

always @(posedge core_clk) begin
  if (!nrst) begin
    prdata <= 32'h0;
    pslverr <= 1'b0;
  end else if (psel && !penable) begin
    pslverr <= 1'b0;
    prdata <= 32'h0;
    case (paddr)
      `SPR_A_CTRL: prdata <= {30'h0, pol};
      `SPR_A_STAT: prdata <= {27'h0, loading, show_sp, fault_led,
        process_relay_channel};
      `SPR_A_SP0: prdata <= {16'h0, sp_ram[0]};
      `SPR_A_SP1: prdata <= {16'h0, sp_ram[1]};
      default: pslverr <= 1'b1;
    endcase
  end
end

always @(posedge core_clk) begin
  if (!nrst) begin
    pol <= `SPR_CTRL_RST;
  end else if (apb_wr && paddr == `SPR_A_CTRL) begin
    pol <= pwdata[1:0];
  end
end

// ----------------------------------------
// setpoint ram and checksum
// ----------------------------------------
always @(posedge core_clk) begin
  if (!nrst) begin
    sp_ram[0] <= 16'h0;
    sp_ram[1] <= 16'h0;
    csum <= 16'h0;
  end else if (ld_wr) begin
    sp_ram[ld_idx] <= ld_word;
    if (ld_idx) begin
      csum <= sp_ram[0] + ld_word;
    end
  end else if (do_step) begin
    sp_ram[ui_ch] <= stp[15:0];
    csum <= sum - sp_ram[ui_ch] + stp[15:0];
  end
end

// periodic integrity check
always @(posedge core_clk) begin
  if (!nrst || chk_tick) begin
    chk_tmr <= 32'h0;
  end else begin
    chk_tmr <= chk_tmr + 32'h1;
  end
end

always @(posedge core_clk) begin
  if (!nrst) begin
    fault_led <= 1'b0;
  end else if (mismatch) begin
    fault_led <= 1'b1;
  end else if (apb_wr && paddr == `SPR_A_STAT &&
      pwdata[`SPR_ST_FAULT]) begin
    fault_led <= 1'b0;
  end
end

// ----------------------------------------
// non-volatile memory sequencer
// ----------------------------------------
always @(posedge core_clk) begin
  if (!nrst) begin
    nv_st <= NV_LOAD;
    ld_idx <= 1'b0;
    wr_idx <= 1'b0;
    wr_pend <= 2'h0;
    nv_req <= 1'b0;
    nv_we <= 1'b0;
    nv_addr <= 1'b0;
    nv_wdata <= 16'h0;
  end else begin
    if (commit && dirty) begin
      wr_pend[ui_ch] <= 1'b1;
    end
    case (nv_st)
      NV_LOAD: begin
        nv_req <= !nv_ack;
        nv_we <= 1'b0;
        nv_addr <= ld_idx;
        if (nv_ack) begin
          ld_idx <= ~ld_idx;
          if (ld_idx) begin
            nv_st <= NV_IDLE;
          end
        end
      end
      NV_IDLE: begin
        if (mismatch) begin
          ld_idx <= 1'b0;
          nv_st <= NV_LOAD;
        end else if (wr_pend != 2'h0) begin
          wr_idx <= !wr_pend[0];
          nv_addr <= !wr_pend[0];
          nv_wdata <= sp_ram[!wr_pend[0]];
          nv_we <= 1'b1;
          nv_req <= 1'b1;
          nv_st <= NV_WR;
        end
      end
      NV_WR: begin
        if (nv_ack) begin
          nv_req <= 1'b0;
          nv_we <= 1'b0;
          if (!(commit && dirty && ui_ch == wr_idx)) begin
            wr_pend[wr_idx] <= 1'b0;
          end
          nv_st <= NV_IDLE;
        end
      end
      default: nv_st <= NV_LOAD;
    endcase
  end
end

// ----------------------------------------
// button handling and setpoint display
// ----------------------------------------
always @(posedge core_clk) begin
  if (!nrst) begin
    ui_st <= UI_IDLE;
    ui_tmr <= 32'h0;
    ui_ch <= 1'b0;
    ui_up <= 1'b0;
    fast <= 1'b0;
    dirty <= 1'b0;
    show_sp <= 1'b0;
  end else begin
    ui_tmr <= ui_tmr + 32'h1;
    case (ui_st)
      UI_IDLE: begin
        if (btn && !loading) begin
          ui_ch <= chan_sel;
          ui_up <= btn_up;
          ui_tmr <= 32'h0;
          show_sp <= 1'b1;
          ui_st <= UI_PRESS;
        end
      end
      UI_PRESS: begin
        if (!btn) begin
          ui_tmr <= 32'h0;
          ui_st <= UI_SHOW;
        end else if (do_step) begin
          ui_tmr <= 32'h0;
          fast <= 1'b0;
          dirty <= 1'b1;
          ui_st <= UI_SCROLL;
        end
      end
      UI_SCROLL: begin
        if (!btn) begin
          ui_tmr <= 32'h0;
          ui_st <= UI_SHOW;
        end else if (do_step) begin
          ui_tmr <= 32'h0;
          if (stp[16]) begin
            fast <= 1'b1;
          end
        end
      end
      UI_SHOW: begin
        if (btn) begin
          ui_up <= btn_up;
          ui_tmr <= 32'h0;
          ui_st <= UI_PRESS;
        end else if (commit) begin
          show_sp <= 1'b0;
          dirty <= 1'b0;
          ui_st <= UI_IDLE;
        end
      end
      default: ui_st <= UI_IDLE;
    endcase
  end
end

always @(posedge core_clk) begin
  if (!nrst) begin
    sp_disp_word <= 16'h0;
  end else begin
    sp_disp_word <= sp_ram[ui_ch];
  end
end

// ----------------------------------------
// pressure capture from the display bus
// ----------------------------------------
always @(posedge core_clk) begin
  if (!nrst) begin
    p_key <= 12'h0;
    p_ovf <= 1'b1;
  end else if (disp_valid && !show_sp && !degas) begin
    p_key <= key(disp_word);
    p_ovf <= disp_ovf;
  end
end

// ----------------------------------------
// per-channel decision and relay drive
// ----------------------------------------
genvar c;
generate
  for (c = 0; c < 2; c = c + 1) begin : g_ch
    wire [11:0] sk = key(sp_ram[c]);
    wire auto_on = pol[c] ? !low[c] : low[c];
    always @(posedge core_clk) begin
      if (!nrst) begin
        low[c] <= 1'b0;
      end else if (!degas && !loading) begin
        if (sk != 12'h0 && p_key < sk) begin
          low[c] <= 1'b1;
        end else if (p_key >= off_key(sp_ram[c]) || sk == 12'h0) begin
          low[c] <= 1'b0;
        end
      end
    end
    always @(posedge core_clk) begin
      if (!nrst) begin
        process_relay_channel[c] <= 1'b0;
      end else if (ovr_on[c]) begin
        process_relay_channel[c] <= 1'b1;
      end else if (ovr_off[c]) begin
        process_relay_channel[c] <= 1'b0;
      end else if (!gauge_on || loading) begin
        process_relay_channel[c] <= 1'b0;
      end else if (!degas) begin
        process_relay_channel[c] <= !p_ovf && auto_on;
      end
    end
  end
endgenerate

endmodule
`default_nettype wire

// [dv/spr_nvmem.sv]
// serial setpoint memory model answering the controller's nv port
`default_nettype none
module spr_nvmem #(
  parameter logic [15:0] W0 = 16'h0,
  parameter logic [15:0] W1 = 16'h0,
  parameter int LAT = 2
) (
  // clock
  input wire logic core_clk,
  // request side
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic nv_addr,
  input wire logic [15:0] nv_wdata,
  // answer side
  output logic nv_ack,
  output logic [15:0] nv_rdata
);
  logic [15:0] mem [2];
  int cnt;
  initial begin
    mem[0] = W0;
    mem[1] = W1;
    nv_ack = 1'h0;
    nv_rdata = 16'h0;
    cnt = 0;
  end
  always @(posedge core_clk) begin
    nv_ack <= 1'h0;
    // read word is only meaningful in the ack cycle
    nv_rdata <= ~nv_rdata;
    if (!nv_req || nv_ack) begin
      cnt <= 0;
    end else if (cnt < LAT) begin
      cnt <= cnt + 1;
    end else begin
      nv_ack <= 1'h1;
      cnt <= 0;
      if (nv_we) mem[nv_addr] <= nv_wdata;
      else nv_rdata <= mem[nv_addr];
    end
  end
endmodule
`default_nettype wire

// [dv/spr_ctrl_sva.sv]
// port assertions for the setpoint relay controller
`default_nettype none
module spr_ctrl_sva #(
  parameter [31:0] SHOW_CYC = 32'h28
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // panel and gauge
  input wire logic gauge_on,
  input wire logic degas,
  input wire logic btn_up,
  input wire logic btn_dn,
  input wire logic [1:0] ovr_on,
  input wire logic [1:0] ovr_off,
  // outputs and nv acknowledge
  input wire logic show_sp,
  input wire logic [1:0] process_relay_channel,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic nv_addr,
  input wire logic [15:0] nv_wdata,
  input wire logic nv_ack
);
  // cycles since both adjust buttons went low
  logic [31:0] idle_n;
  always @(posedge core_clk) begin
    if (!nrst || btn_up || btn_dn) idle_n <= 32'h0;
    else if (idle_n < SHOW_CYC + 32'h8) idle_n <= idle_n + 32'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_ovr_on;
    ovr_on[0] |=> process_relay_channel[0];
  endproperty
  a_ovr_on: assert property (p_ovr_on)
    else $error("force on ignored");
  property p_ovr_off;
    ovr_off[1] && !ovr_on[1] |=> !process_relay_channel[1];
  endproperty
  a_ovr_off: assert property (p_ovr_off)
    else $error("force off ignored");
  property p_gauge_off;
    !gauge_on |=> (process_relay_channel & ~$past(ovr_on)) == 2'h0;
  endproperty
  a_gauge_off: assert property (p_gauge_off)
    else $error("relay active with gauge off");
  property p_degas;
    (degas && gauge_on && ovr_on == 2'h0 && ovr_off == 2'h0)[*3]
      |=> $stable(process_relay_channel);
  endproperty
  a_degas: assert property (p_degas)
    else $error("relay moved during degas");
  property p_show_fell;
    $fell(show_sp) |-> idle_n >= SHOW_CYC - 32'h1;
  endproperty
  a_show_fell: assert property (p_show_fell)
    else $error("setpoint display ended early");
  property p_show_end;
    idle_n == SHOW_CYC + 32'h3 |-> !show_sp;
  endproperty
  a_show_end: assert property (p_show_end)
    else $error("setpoint display ended late");
  property p_nv_hold;
    nv_req && !nv_ack |=> nv_req && $stable(nv_addr) && $stable(nv_we)
      && $stable(nv_wdata);
  endproperty
  a_nv_hold: assert property (p_nv_hold)
    else $error("nv request changed before ack");
  property p_nv_drop;
    nv_ack |=> !nv_req;
  endproperty
  a_nv_drop: assert property (p_nv_drop)
    else $error("nv request held after ack");
endmodule
bind spr_ctrl spr_ctrl_sva #(.SHOW_CYC(SHOW_CYC)) u_sva (.core_clk,
  .nrst, .gauge_on, .degas, .btn_up, .btn_dn, .ovr_on, .ovr_off,
  .show_sp, .process_relay_channel, .nv_req, .nv_we, .nv_addr,
  .nv_wdata, .nv_ack);
`default_nettype wire

// [dv/tb_setpoint_relay_control.sv]
// self-checking bench for the setpoint relay controller
`include "spr_defines.vh"
`default_nettype none
module tb_setpoint_relay_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // signals
  // ----
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic disp_valid, disp_ovf, gauge_on, degas, btn_up, btn_dn, chan_sel;
  logic [15:0] disp_word, sp_disp_word, nv_wdata, nv_rdata;
  logic [1:0] ovr_on, ovr_off, rly;
  logic show_sp, fault_led, nv_req, nv_we, nv_addr, nv_ack;
  int n_errors = 0;
  int num_checks = 0;
  spr_ctrl #(.SHOW_CYC(40), .HOLD_CYC(10), .SLOW_CYC(4), .FAST_CYC(2),
    .CHK_CYC(50)) DUT (.core_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .disp_valid, .disp_word,
    .disp_ovf, .gauge_on, .degas, .btn_up, .btn_dn, .chan_sel, .ovr_on,
    .ovr_off, .show_sp, .sp_disp_word, .process_relay_channel(rly),
    .fault_led, .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata);
  // second word is not a valid setpoint
  spr_nvmem #(.W0(16'h66fd), .W1(16'hff00), .LAT(3)) u_nv (.core_clk,
    .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata);
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic send(input logic [15:0] w, input logic o);
    disp_valid <= 1'h1;
    disp_word <= w;
    disp_ovf <= o;
    @(posedge core_clk);
    disp_valid <= 1'h0;
    disp_ovf <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task report_and_stop;
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_load;
    for (int i = 0; i < 40; i++) begin
      apb(1'h0, `SPR_A_STAT, 32'h0);
      if (rdat[`SPR_ST_LOAD] === 1'h0) break;
    end
    chk("load", 32'h0, rdat[`SPR_ST_LOAD]);
    chk("fault", 32'h0, rdat[`SPR_ST_FAULT]);
    apb(1'h0, `SPR_A_SP0, 32'h0);
    chk("sp0", 32'h66fd, rdat);
    apb(1'h0, `SPR_A_SP1, 32'h0);
    chk("sp1", 32'h0, rdat);
    apb(1'h0, `SPR_A_CTRL, 32'h0);
    chk("ctrl", `SPR_CTRL_RST, rdat);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, err);
  endtask
  task automatic t_auto;
    send(16'h65fd, 1'h0);
    chk("below", 32'h1, rly);
    send(16'h73fd, 1'h0);
    chk("hyst", 32'h1, rly);
    send(16'h74fd, 1'h0);
    chk("release", 32'h0, rly);
    send(16'h66fd, 1'h0);
    chk("at_sp", 32'h0, rly);
    apb(1'h1, `SPR_A_CTRL, 32'h2);
    send(16'h65fd, 1'h0);
    chk("zero_rev", 32'h3, rly);
    send(16'h65fd, 1'h1);
    chk("ovf", 32'h0, rly);
  endtask
  task automatic t_override;
    send(16'h74fd, 1'h0);
    chk("rev_above", 32'h2, rly);
    ovr_on <= 2'h1;
    ovr_off <= 2'h2;
    repeat (2) @(posedge core_clk);
    chk("override", 32'h1, rly);
    gauge_on <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk("ovr_gauge_off", 32'h1, rly);
    ovr_on <= 2'h0;
    ovr_off <= 2'h0;
    repeat (2) @(posedge core_clk);
    chk("gauge_off", 32'h0, rly);
    gauge_on <= 1'h1;
  endtask
  task automatic t_degas;
    send(16'h65fd, 1'h0);
    chk("both", 32'h3, rly);
    degas <= 1'h1;
    @(posedge core_clk);
    send(16'h74fd, 1'h0);
    chk("degas_hold", 32'h3, rly);
    degas <= 1'h0;
    send(16'h74fd, 1'h0);
    chk("after_degas", 32'h2, rly);
  endtask
  task automatic t_button;
    int i;
    btn_up <= 1'h1;
    repeat (3) @(posedge core_clk);
    btn_up <= 1'h0;
    chk("show", 32'h1, show_sp);
    chk("show_word", 32'h66fd, sp_disp_word);
    send(16'h65fd, 1'h0);
    chk("snoop_off", 32'h2, rly);
    for (i = 0; i < 60 && show_sp === 1'h1; i++) @(posedge core_clk);
    chk("show_end", 32'h0, show_sp);
    chk("no_store", 32'h0, nv_req);
    btn_up <= 1'h1;
    repeat (12) @(posedge core_clk);
    btn_up <= 1'h0;
    for (i = 0; i < 80 && nv_req !== 1'h1; i++) @(posedge core_clk);
    chk("store_we", 32'h1, nv_we);
    chk("store_addr", 32'h0, nv_addr);
    chk("store_word", 32'h67fd, nv_wdata);
    for (i = 0; i < 20 && show_sp === 1'h1; i++) @(posedge core_clk);
    apb(1'h0, `SPR_A_SP0, 32'h0);
    chk("sp0_new", 32'h67fd, rdat);
    repeat (60) @(posedge core_clk);
    chk("no_fault", 32'h0, fault_led);
  endtask
  // second channel, down button held at the zero floor
  task automatic t_down;
    int i;
    chan_sel <= 1'h1;
    btn_dn <= 1'h1;
    repeat (12) @(posedge core_clk);
    btn_dn <= 1'h0;
    chan_sel <= 1'h0;
    chk("dn_show", 32'h1, show_sp);
    chk("dn_word", 32'h0, sp_disp_word);
    for (i = 0; i < 80 && nv_req !== 1'h1; i++) @(posedge core_clk);
    chk("dn_we", 32'h1, nv_we);
    chk("dn_addr", 32'h1, nv_addr);
    chk("dn_wdata", 32'h0, nv_wdata);
    for (i = 0; i < 20 && show_sp === 1'h1; i++) @(posedge core_clk);
    apb(1'h0, `SPR_A_SP1, 32'h0);
    chk("sp1_floor", 32'h0, rdat);
  endtask
  // ----
  // clock, sequence and watchdog
  // ----
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, disp_valid, disp_ovf} = 6'h0;
    {degas, btn_up, btn_dn, chan_sel} = 4'h0;
    {paddr, pwdata, disp_word, ovr_on, ovr_off} = 60'h0;
    gauge_on = 1'h1;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    t_load;
    t_auto;
    t_override;
    t_degas;
    t_button;
    t_down;
    report_and_stop;
  end
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
